// ---- logic/rsc_pkg.sv ----
// Purpose: shared constants for the radio state configuration registers
// Assumes: 8-bit register port with 6-bit address from the config port
// Notes: offsets are byte-wide register addresses
package rsc_pkg;
	localparam logic [5:0] ADDR_DEVIATION = 6'h15;
	localparam logic [5:0] ADDR_SM_TWO = 6'h16;
	localparam logic [5:0] ADDR_SM_ONE = 6'h17;
	localparam logic [5:0] ADDR_SM_ZERO = 6'h18;
	localparam logic [7:0] MASK_DEVIATION = 8'h77;
	localparam logic [7:0] MASK_SM_TWO = 8'h1F;
	localparam logic [7:0] MASK_SM_ONE = 8'h3F;
	localparam logic [7:0] MASK_SM_ZERO = 8'h3F;
	localparam logic [7:0] RST_DEVIATION = 8'h47;
	localparam logic [7:0] RST_SM_TWO = 8'h07;
	localparam logic [7:0] RST_SM_ONE = 8'h30;
	localparam logic [7:0] RST_SM_ZERO = 8'h00;
	localparam int CS_TERM_BIT = 4;
	localparam int RXOFF_LSB = 2;
	localparam int AUTOCAL_LSB = 4;
	localparam int DEV_E_LSB = 4;
	localparam int DEV_M_LSB = 0;
	localparam logic [2:0] MOD_OOK = 3'h3;
	localparam logic [1:0] RXOFF_IDLE = 2'h0;
	localparam logic [1:0] RXOFF_STAY = 2'h3;
	localparam logic [1:0] CAL_NEVER = 2'h0;
	localparam logic [1:0] CAL_IDLE_TO_RX = 2'h1;
	localparam logic [1:0] CAL_RX_TO_IDLE = 2'h2;
	localparam logic [1:0] CAL_FOURTH = 2'h3;
	localparam int OOK_TIMEOUT_SYMBOLS = 8;
	localparam int CAL_EVERY_NTH = 4;
	typedef enum logic [1:0] {
		RSC_IDLE = 2'b00,
		RSC_CAL = 2'b01,
		RSC_RX = 2'b10
	} rsc_state_type;
endpackage

// ---- logic/rsc_cal_counter.sv ----
// Purpose: counts automatic rx to idle returns, fires on every fourth
// Assumes: tick is a one-cycle pulse
// Notes: counter cleared by clr
`timescale 1ns/1ps
module rsc_cal_counter #(
	parameter int PERIOD = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic clr,
	output logic fire
);
	logic [2:0] cnt_q;
	logic last;
	assign last = (cnt_q == 3'(PERIOD - 1));
	assign fire = tick && last;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			cnt_q <= 3'h0;
		else if (clr || fire)
			cnt_q <= 3'h0;
		else if (tick)
			cnt_q <= cnt_q + 3'h1;
	end
endmodule // rsc_cal_counter

// ---- logic/rsc_regs.sv ----
// Purpose: deviation and radio state machine configuration registers
// Assumes: synchronous byte register port; symbol_tick from the modem
// Notes: drives a small rx/idle/calibrate control machine
`timescale 1ns/1ps
module rsc_regs #(
	parameter int OOK_SYMBOLS = rsc_pkg::OOK_TIMEOUT_SYMBOLS,
	parameter int CAL_PERIOD = rsc_pkg::CAL_EVERY_NTH
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [2:0] mod_format,
	input wire logic rx_strobe,
	input wire logic idle_strobe,
	input wire logic calibrate_command_strobe,
	input wire logic cal_done,
	input wire logic packet_done,
	input wire logic carrier_sense,
	input wire logic symbol_tick,
	output logic [7:0] reg_rdata,
	output logic [2:0] deviation_e,
	output logic [2:0] deviation_m,
	output logic synth_cal_start,
	output logic rx_active,
	output logic rx_timeout
);
	logic [7:0] dev_q;
	logic [7:0] sm2_q;
	logic [7:0] sm1_q;
	logic [7:0] sm0_q;
	logic [7:0] rdata_q;
	logic [2:0] dev_e_q;
	logic [2:0] dev_m_q;
	logic cal_start_q;
	logic rx_act_q;
	logic timeout_q;
	// sized for up to 16 symbols; a longer timeout needs a wider count
	logic [3:0] sym_cnt_q;
	logic cs_seen_q;
	logic cal_to_rx_q;
	rsc_pkg::rsc_state_type state_q;
	rsc_pkg::rsc_state_type state_d;
	logic wr_dev;
	logic wr_sm2;
	logic wr_sm1;
	logic wr_sm0;
	logic [7:0] rd_mux;
	logic [2:0] dev_e_field;
	logic [2:0] dev_m_field;
	logic is_ook;
	logic cs_term;
	logic ook_tmo;
	logic cs_end;
	logic auto_exit;
	logic pkt_stay;
	logic [1:0] autocal;
	logic [1:0] rxoff;
	logic cal_on_exit;
	logic fourth_fire;
	logic cal_req_rx;
	logic cal_req_exit;
	logic fourth_tick;
	logic fourth_clr;

	assign wr_dev = reg_wr && (reg_addr == rsc_pkg::ADDR_DEVIATION);
	assign wr_sm2 = reg_wr && (reg_addr == rsc_pkg::ADDR_SM_TWO);
	assign wr_sm1 = reg_wr && (reg_addr == rsc_pkg::ADDR_SM_ONE);
	assign wr_sm0 = reg_wr && (reg_addr == rsc_pkg::ADDR_SM_ZERO);
	// unmapped addresses read as zero
	assign rd_mux = (reg_addr == rsc_pkg::ADDR_DEVIATION) ? dev_q :
		(reg_addr == rsc_pkg::ADDR_SM_TWO) ? sm2_q :
		(reg_addr == rsc_pkg::ADDR_SM_ONE) ? sm1_q :
		(reg_addr == rsc_pkg::ADDR_SM_ZERO) ? sm0_q : 8'h00;

	assign is_ook = (mod_format == rsc_pkg::MOD_OOK);
	assign cs_term = sm2_q[rsc_pkg::CS_TERM_BIT];
	assign rxoff = sm1_q[rsc_pkg::RXOFF_LSB +: 2];
	assign autocal = sm0_q[rsc_pkg::AUTOCAL_LSB +: 2];
	assign dev_e_field = dev_q[rsc_pkg::DEV_E_LSB +: 3];
	assign dev_m_field = dev_q[rsc_pkg::DEV_M_LSB +: 3];
	// ook early timeout: 8 symbols elapsed with no carrier seen
	assign ook_tmo = cs_term && is_ook && !cs_seen_q && symbol_tick &&
		(sym_cnt_q == 4'(OOK_SYMBOLS - 1));
	// carrier lost after being seen ends rx early
	assign cs_end = cs_term && cs_seen_q && !carrier_sense;
	assign pkt_stay = (rxoff == rsc_pkg::RXOFF_STAY);
	assign auto_exit = (state_q == rsc_pkg::RSC_RX) &&
		(ook_tmo || cs_end || (packet_done && !pkt_stay));
	assign cal_on_exit = auto_exit &&
		((autocal == rsc_pkg::CAL_RX_TO_IDLE) || fourth_fire);
	assign cal_req_rx = rx_strobe && (state_q == rsc_pkg::RSC_IDLE) &&
		(autocal == rsc_pkg::CAL_IDLE_TO_RX);
	// manual strobe is the only path when autocal is never
	assign cal_req_exit = cal_on_exit ||
		(calibrate_command_strobe && (state_q == rsc_pkg::RSC_IDLE));

	// every-fourth counter idles at zero unless that mode is selected
	assign fourth_tick = auto_exit && (autocal == rsc_pkg::CAL_FOURTH);
	assign fourth_clr = (autocal != rsc_pkg::CAL_FOURTH);
	rsc_cal_counter #(
		.PERIOD(CAL_PERIOD)
	) u_cnt (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick(fourth_tick),
		.clr(fourth_clr),
		.fire(fourth_fire)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			rsc_pkg::RSC_IDLE: begin
				if (cal_req_rx || cal_req_exit)
					state_d = rsc_pkg::RSC_CAL;
				else if (rx_strobe)
					state_d = rsc_pkg::RSC_RX;
			end
			rsc_pkg::RSC_CAL: begin
				if (cal_done)
					state_d = cal_to_rx_q ? rsc_pkg::RSC_RX : rsc_pkg::RSC_IDLE;
			end
			rsc_pkg::RSC_RX: begin
				// idle strobe is a manual exit, so it never calibrates
				if (cal_on_exit)
					state_d = rsc_pkg::RSC_CAL;
				else if (auto_exit || idle_strobe)
					state_d = rsc_pkg::RSC_IDLE;
			end
			default: state_d = rsc_pkg::RSC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_q <= rsc_pkg::RST_DEVIATION;
			sm2_q <= rsc_pkg::RST_SM_TWO;
			sm1_q <= rsc_pkg::RST_SM_ONE;
			sm0_q <= rsc_pkg::RST_SM_ZERO;
		end else begin
			// reserved bits are masked on write so they always read zero
			if (wr_dev)
				dev_q <= reg_wdata & rsc_pkg::MASK_DEVIATION;
			if (wr_sm2)
				sm2_q <= reg_wdata & rsc_pkg::MASK_SM_TWO;
			if (wr_sm1)
				sm1_q <= reg_wdata & rsc_pkg::MASK_SM_ONE;
			if (wr_sm0)
				sm0_q <= reg_wdata & rsc_pkg::MASK_SM_ZERO;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
			dev_e_q <= 3'h0;
			dev_m_q <= 3'h0;
		end else begin
			if (reg_rd)
				rdata_q <= rd_mux;
			// ook ignores deviation, so demod sees zero
			dev_e_q <= is_ook ? 3'h0 : dev_e_field;
			dev_m_q <= is_ook ? 3'h0 : dev_m_field;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= rsc_pkg::RSC_IDLE;
			cal_to_rx_q <= 1'b0;
			cal_start_q <= 1'b0;
			rx_act_q <= 1'b0;
			timeout_q <= 1'b0;
		end else begin
			state_q <= state_d;
			// remembers whether this calibration ends in rx
			if (state_q != rsc_pkg::RSC_CAL)
				cal_to_rx_q <= cal_req_rx;
			cal_start_q <= (state_d == rsc_pkg::RSC_CAL) &&
				(state_q != rsc_pkg::RSC_CAL);
			rx_act_q <= (state_d == rsc_pkg::RSC_RX);
			timeout_q <= ook_tmo && (state_q == rsc_pkg::RSC_RX);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sym_cnt_q <= 4'h0;
			cs_seen_q <= 1'b0;
		end else if (state_q != rsc_pkg::RSC_RX) begin
			sym_cnt_q <= 4'h0;
			cs_seen_q <= 1'b0;
		end else begin
			// carrier must be seen once before its loss can end rx
			if (carrier_sense)
				cs_seen_q <= 1'b1;
			// saturating, so one rx visit gives at most one timeout
			if (symbol_tick && sym_cnt_q != 4'hF)
				sym_cnt_q <= sym_cnt_q + 4'h1;
		end
	end

	assign reg_rdata = rdata_q;
	assign deviation_e = dev_e_q;
	assign deviation_m = dev_m_q;
	assign synth_cal_start = cal_start_q;
	assign rx_active = rx_act_q;
	assign rx_timeout = timeout_q;
endmodule // rsc_regs

// ---- bench/rsc_synth_model.sv ----
// Purpose: synthesizer and modem stand-in at the far side of rsc_regs
// Assumes: each synth_cal_start is answered by cal_done after DLY cycles
// Notes: symbol ticks run only while sym_en is high
`timescale 1ns/1ps
module rsc_synth_model #(
	parameter int DLY = 3
) (
	input wire logic core_clk,
	input wire logic synth_cal_start,
	input wire logic sym_en,
	output logic cal_done,
	output logic symbol_tick
);
	initial begin
		cal_done = 1'h0;
		symbol_tick = 1'h0;
	end
	// one calibration at a time, as the real synthesizer allows
	always @(posedge core_clk) if (synth_cal_start) begin
		repeat (DLY) @(posedge core_clk);
		cal_done <= 1'h1;
		@(posedge core_clk);
		cal_done <= 1'h0;
	end
	always @(posedge core_clk) symbol_tick <= sym_en && !symbol_tick;
endmodule // rsc_synth_model

// ---- bench/rsc_regs_monitor.sv ----
// Purpose: port checks for rsc_regs
// Assumes: single clock domain, async active-low reset
// Notes: bound into every rsc_regs instance
`timescale 1ns/1ps
module rsc_regs_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reg_rd,
	input wire logic [2:0] mod_format,
	input wire logic rx_strobe,
	input wire logic cal_done,
	input wire logic symbol_tick,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] deviation_e,
	input wire logic [2:0] deviation_m,
	input wire logic synth_cal_start,
	input wire logic rx_active,
	input wire logic rx_timeout
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_dev_ook_zero: assert property ((mod_format == 3'h3) [*2] |->
		deviation_e == 3'h0 && deviation_m == 3'h0) else $error("ook dev");
	chk_cal_one_cycle: assert property (synth_cal_start |=>
		!synth_cal_start) else $error("cal start too long");
	chk_timeout_one: assert property (rx_timeout |=> !rx_timeout)
		else $error("timeout too long");
	chk_timeout_tick: assert property (rx_timeout |-> $past(symbol_tick))
		else $error("timeout without tick");
	chk_cal_outside_rx: assert property (synth_cal_start |-> !rx_active)
		else $error("cal start in rx");
	chk_rx_entry_cause: assert property ($rose(rx_active) |->
		$past(rx_strobe) || $past(cal_done)) else $error("rx without cause");
	chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	chk_rdata_top_zero: assert property (!reg_rdata[7])
		else $error("unused bit set");
endmodule // rsc_regs_monitor
bind rsc_regs rsc_regs_monitor u_rsc_regs_monitor (.core_clk(core_clk),
	.rst_n(rst_n), .reg_rd(reg_rd), .mod_format(mod_format),
	.rx_strobe(rx_strobe), .cal_done(cal_done), .symbol_tick(symbol_tick),
	.reg_rdata(reg_rdata), .deviation_e(deviation_e),
	.deviation_m(deviation_m), .synth_cal_start(synth_cal_start),
	.rx_active(rx_active), .rx_timeout(rx_timeout));

// ---- bench/tb.sv ----
// Purpose: self-checking bench for rsc_regs
// Assumes: strobes st[0] rx, st[1] idle, st[2] calibrate, st[3] packet
// Notes: calibrations and timeouts are counted from the output pulses
`timescale 1ns/1ps
module tb;
	logic core_clk, rst_n, reg_wr, reg_rd, carrier_sense, sym_en;
	logic cal_done, symbol_tick, synth_cal_start, rx_active, rx_timeout;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [2:0] mod_format, deviation_e, deviation_m;
	logic [3:0] st;
	int fail_count, checks, n_cal, n_to;
	rsc_regs u_rsc_regs (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .mod_format(mod_format), .rx_strobe(st[0]),
		.idle_strobe(st[1]), .calibrate_command_strobe(st[2]),
		.cal_done(cal_done), .packet_done(st[3]),
		.carrier_sense(carrier_sense), .symbol_tick(symbol_tick),
		.reg_rdata(reg_rdata), .deviation_e(deviation_e),
		.deviation_m(deviation_m), .synth_cal_start(synth_cal_start),
		.rx_active(rx_active), .rx_timeout(rx_timeout));
	rsc_synth_model u_rsc_synth_model (.core_clk(core_clk),
		.synth_cal_start(synth_cal_start), .sym_en(sym_en),
		.cal_done(cal_done), .symbol_tick(symbol_tick));
	always @(posedge core_clk) n_cal += (synth_cal_start === 1'h1);
	always @(posedge core_clk) n_to += (rx_timeout === 1'h1);
	task cmp(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task clk(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge core_clk);
		{reg_addr, reg_rd} <= {a, 1'h1};
		@(posedge core_clk);
		reg_rd <= 1'h0;
		clk(1);
		cmp(reg_rdata, e);
	endtask
	task go(input logic [3:0] s);
		@(posedge core_clk);
		st <= s;
		@(posedge core_clk);
		st <= 4'h0;
		#1;
	endtask
	task wt(input logic e);
		repeat (30) if (rx_active !== e) clk(1);
		cmp(rx_active, e);
	endtask
	task t_regs;
		cmp(deviation_e, 3'h4);
		cmp(deviation_m, 3'h7);
		rd(6'h15, 8'h47);
		rd(6'h16, 8'h07);
		rd(6'h17, 8'h30);
		rd(6'h18, 8'h00);
		rd(6'h00, 8'h00);
		for (int i = 0; i < 4; i++) wr(6'h15 + 6'(i), 8'hFF);
		rd(6'h15, 8'h77);
		rd(6'h16, 8'h1F);
		rd(6'h17, 8'h3F);
		rd(6'h18, 8'h3F);
		wr(6'h15, 8'h35);
		clk(2);
		cmp({deviation_e, deviation_m}, 8'h1D);
		@(posedge core_clk);
		mod_format <= 3'h3;
		clk(2);
		cmp({deviation_e, deviation_m}, 8'h00);
		@(posedge core_clk);
		mod_format <= 3'h0;
		wr(6'h16, 8'h00);
		wr(6'h17, 8'h00);
	endtask
	task t_cal;
		wr(6'h18, 8'h00);
		n_cal = 0;
		go(4'h1);
		wt(1'h1);
		go(4'h2);
		wt(1'h0);
		cmp(8'(n_cal), 8'h00);
		go(4'h4);
		clk(8);
		cmp(8'(n_cal), 8'h01);
		wr(6'h18, 8'h10);
		go(4'h1);
		wt(1'h1);
		cmp(8'(n_cal), 8'h02);
		wr(6'h18, 8'h20);
		go(4'h8);
		wt(1'h0);
		clk(8);
		cmp(8'(n_cal), 8'h03);
		wr(6'h18, 8'h30);
		n_cal = 0;
		repeat (4) begin
			go(4'h1);
			wt(1'h1);
			go(4'h8);
			wt(1'h0);
			clk(8);
		end
		cmp(8'(n_cal), 8'h01);
	endtask
	task t_stay;
		wr(6'h18, 8'h00);
		wr(6'h17, 8'h0C);
		go(4'h1);
		wt(1'h1);
		go(4'h8);
		clk(4);
		cmp(rx_active, 1'h1);
		go(4'h2);
		wt(1'h0);
	endtask
	task t_term;
		wr(6'h16, 8'h10);
		go(4'h1);
		wt(1'h1);
		@(posedge core_clk);
		carrier_sense <= 1'h1;
		clk(4);
		cmp(rx_active, 1'h1);
		@(posedge core_clk);
		carrier_sense <= 1'h0;
		wt(1'h0);
		@(posedge core_clk);
		mod_format <= 3'h3;
		n_to = 0;
		go(4'h1);
		wt(1'h1);
		@(posedge core_clk);
		sym_en <= 1'h1;
		clk(24);
		cmp(8'(n_to), 8'h01);
		cmp(rx_active, 1'h0);
	endtask
	task close_out;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		{rst_n, reg_wr, reg_rd, carrier_sense, sym_en, st} = 9'h000;
		{reg_addr, reg_wdata, mod_format} = 17'h00000;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'h1;
		clk(1);
		t_regs;
		t_cal;
		t_stay;
		t_term;
		close_out;
	end
	// the full sequence needs well under 2000 cycles
	initial begin
		#200000;
		fail_count++;
		close_out;
	end
endmodule // tb
